// file: design/rcdfr_defines.vh
// Constants for the reset cause and debug force reset block.
// Assumes inclusion by bare name from the design folder.
`ifndef RCDFR_DEFINES_VH
`define RCDFR_DEFINES_VH

// ============================================================
// Register selects (no address bus: one select per register)
// ============================================================
`define RCDFR_STATUS_SEL 1'h0
`define RCDFR_FORCE_SEL 1'h1

// ============================================================
// Status field positions
// ============================================================
`define RCDFR_BIT_POWER_ON 7
`define RCDFR_BIT_EXT_PIN 6
`define RCDFR_BIT_WATCHDOG 5
`define RCDFR_BIT_ILLEGAL 4
`define RCDFR_BIT_CLOCK_GEN 2
`define RCDFR_BIT_LOW_VOLT 1

// ============================================================
// Force register field and read value
// ============================================================
`define RCDFR_BIT_FORCE 0
`define RCDFR_FORCE_READ 8'h00
`define RCDFR_ZERO_BYTE 8'h00

// ============================================================
// Unused status positions
// ============================================================
`define RCDFR_BIT_RSVD_HI 3
`define RCDFR_BIT_RSVD_LO 0

// ============================================================
// Reset kinds, in falling priority
// ============================================================
`define RCDFR_KIND_DEBUG 2'h0
`define RCDFR_KIND_POWER_ON 2'h1
`define RCDFR_KIND_LOW_VOLT 2'h2
`define RCDFR_KIND_OTHER 2'h3

`endif

// file: design/rcdfr_reset_cause.v
// Reset cause status register and debug force reset register.
// Assumes the reset controller applies rst_n_in for every reset type
// and presents the cause strobes stable while rst_n_in is low.
// Status flags change only while reset is held.
//
// Summary of operation
// - Six read-only flags record latest reset cause
// - Debug forced reset leaves all flags clear
// - Status write restarts watchdog, flags unchanged
// - Power-on sets bits 7 and 1 only
// - Low-voltage keeps bit 7, sets bit 1
// - Other resets clear 7,1; set active sources
// - External pin reset sets bit 6
// - Watchdog expiry sets bit 5; needs enable
// - Illegal opcode, disallowed stop/background sets bit 4
// - Clock generator reset sets bit 2
// - Low-voltage reset needs both enables and trip
// - Stop disables detector unless stop enable set
// - User writes to force register are ignored
// - Force register always reads zero
// - Debug write of bit 0 forces reset
`include "rcdfr_defines.vh"
`default_nettype none

module rcdfr_reset_cause (
    input wire core_clk_in,
    input wire rst_n_in,
    // Cause strobes, held by the reset controller during reset
    input wire cause_power_on_in,
    input wire cause_ext_pin_in,
    input wire cause_watchdog_in,
    input wire cause_illegal_in,
    input wire cause_clock_gen_in,
    input wire cause_low_volt_in,
    input wire cause_debug_force_in,
    // Qualifying settings and conditions
    input wire watchdog_enable_in,
    input wire watchdog_expired_in,
    input wire illegal_opcode_in,
    input wire stop_instr_in,
    input wire stop_allow_in,
    input wire background_entry_instruction_in,
    input wire background_mode_allow_in,
    input wire voltage_detector_enable_in,
    input wire voltage_detector_reset_enable_in,
    input wire voltage_detector_stop_enable_in,
    input wire supply_below_trip_in,
    input wire stop_mode_in,
    // Register port
    input wire reg_sel_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire reg_debug_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    // Actions
    output wire watchdog_restart_out,
    output wire watchdog_reset_req_out,
    output wire illegal_reset_req_out,
    output wire low_volt_reset_req_out,
    output wire detector_active_out,
    output reg force_reset_req_out
);

    // ========================================================
    // State and internal nets
    // ========================================================
    reg [7:0] reset_cause_status;
    reg [7:0] next_status;
    reg [7:0] next_rdata;
    reg [1:0] reset_kind;
    reg in_reset;
    reg next_force;
    reg next_power_on;
    reg next_ext_pin;
    reg next_watchdog;
    reg next_illegal;
    reg next_clock_gen;
    reg next_low_volt;

    wire status_selected;
    wire force_selected;
    wire stop_is_illegal;
    wire background_is_illegal;
    wire detector_live;
    wire force_write_seen;

    // ========================================================
    // Decode helpers
    // ========================================================
    // Register select decode, shared by the write paths
    function sel_matches;
        input sel;
        input target;
        begin
            sel_matches = (sel == target);
        end
    endfunction

    // An instruction is illegal when its permission is withheld
    function disallowed;
        input instr;
        input allow;
        begin
            disallowed = instr & ~allow;
        end
    endfunction

    // ========================================================
    // Status helpers
    // ========================================================
    // Cause priority: debug force, then power-on, then low voltage
    function [1:0] classify_reset;
        input debug_force;
        input power_on;
        input low_volt;
        begin
            if (debug_force) begin
                classify_reset = `RCDFR_KIND_DEBUG;
            end else if (power_on) begin
                classify_reset = `RCDFR_KIND_POWER_ON;
            end else if (low_volt) begin
                classify_reset = `RCDFR_KIND_LOW_VOLT;
            end else begin
                classify_reset = `RCDFR_KIND_OTHER;
            end
        end
    endfunction

    // Packs the six flags; the two unused positions stay zero
    function [7:0] pack_status;
        input power_on;
        input ext_pin;
        input watchdog;
        input illegal;
        input clock_gen;
        input low_volt;
        begin
            pack_status = `RCDFR_ZERO_BYTE;
            pack_status[`RCDFR_BIT_POWER_ON] = power_on;
            pack_status[`RCDFR_BIT_EXT_PIN] = ext_pin;
            pack_status[`RCDFR_BIT_WATCHDOG] = watchdog;
            pack_status[`RCDFR_BIT_ILLEGAL] = illegal;
            pack_status[`RCDFR_BIT_RSVD_HI] = 1'h0;
            pack_status[`RCDFR_BIT_CLOCK_GEN] = clock_gen;
            pack_status[`RCDFR_BIT_LOW_VOLT] = low_volt;
            pack_status[`RCDFR_BIT_RSVD_LO] = 1'h0;
        end
    endfunction

    // ========================================================
    // Watchdog and opcode requests
    // ========================================================
    // Watchdog expiry is blocked when the enable is clear
    assign watchdog_reset_req_out = watchdog_expired_in &
        watchdog_enable_in;

    assign stop_is_illegal = disallowed(stop_instr_in,
        stop_allow_in);

    assign background_is_illegal = disallowed(
        background_entry_instruction_in,
        background_mode_allow_in);

    assign illegal_reset_req_out = illegal_opcode_in |
        stop_is_illegal |
        background_is_illegal;

    // ========================================================
    // Low-voltage detector
    // ========================================================
    assign detector_live = voltage_detector_enable_in &
        (~stop_mode_in | voltage_detector_stop_enable_in);

    assign detector_active_out = detector_live;

    assign low_volt_reset_req_out = detector_live &
        voltage_detector_reset_enable_in &
        supply_below_trip_in;

    // ========================================================
    // Status capture
    // ========================================================
    always @* begin
        reset_kind = classify_reset(cause_debug_force_in,
            cause_power_on_in, cause_low_volt_in);

        next_power_on = 1'h0;
        next_ext_pin = 1'h0;
        next_watchdog = 1'h0;
        next_illegal = 1'h0;
        next_clock_gen = 1'h0;
        next_low_volt = 1'h0;

        case (reset_kind)
            `RCDFR_KIND_DEBUG: begin
                // Forced reset leaves every flag clear
                next_power_on = 1'h0;
                next_low_volt = 1'h0;
            end
            `RCDFR_KIND_POWER_ON: begin
                next_power_on = 1'h1;
                next_low_volt = 1'h1;
            end
            `RCDFR_KIND_LOW_VOLT: begin
                next_power_on =
                    reset_cause_status[`RCDFR_BIT_POWER_ON];
                next_low_volt = 1'h1;
            end
            `RCDFR_KIND_OTHER: begin
                // Several sources may be active at once; all are shown
                next_ext_pin = cause_ext_pin_in;
                next_watchdog = cause_watchdog_in;
                next_illegal = cause_illegal_in;
                next_clock_gen = cause_clock_gen_in;
            end
            default: begin
                next_power_on = 1'h0;
                next_low_volt = 1'h0;
            end
        endcase
        next_status = pack_status(next_power_on, next_ext_pin,
            next_watchdog, next_illegal, next_clock_gen,
            next_low_volt);
    end

    // Flags are loaded while reset is held and frozen afterwards,
    // so bus writes never touch them
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            reset_cause_status <= next_status;
        end else begin
            reset_cause_status <= reset_cause_status;
        end
    end

    // Marks the first cycle after release; restart is held off then
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            in_reset <= 1'h1;
        end else begin
            in_reset <= 1'h0;
        end
    end

    // ========================================================
    // Register access
    // ========================================================
    assign status_selected = sel_matches(reg_sel_in, `RCDFR_STATUS_SEL);
    assign force_selected = sel_matches(reg_sel_in, `RCDFR_FORCE_SEL);

    // Any value written to the status address restarts the watchdog
    assign watchdog_restart_out = reg_wr_in & ~in_reset &
        status_selected;

    // User program writes never carry the debug qualifier
    assign force_write_seen = reg_wr_in & reg_debug_in &
        force_selected;

    always @* begin
        next_force = 1'h0;
        if (force_write_seen) begin
            next_force = reg_wdata_in[`RCDFR_BIT_FORCE];
        end
    end

    // Read data stands until the next read
    always @* begin
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            case (reg_sel_in)
                `RCDFR_STATUS_SEL: begin
                    next_rdata = reset_cause_status;
                end
                `RCDFR_FORCE_SEL: begin
                    next_rdata = `RCDFR_FORCE_READ;
                end
                default: begin
                    next_rdata = `RCDFR_ZERO_BYTE;
                end
            endcase
        end
    end

    // ========================================================
    // Output registers
    // ========================================================
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            force_reset_req_out <= 1'h0;
        end else begin
            force_reset_req_out <= next_force;
        end
    end

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= `RCDFR_ZERO_BYTE;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// file: tb/rcdfr_chk.sv
// Port checker for the reset cause block.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module rcdfr_chk (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_sel_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_debug_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic watchdog_restart_out,
    input wire logic force_reset_req_out,
    input wire logic watchdog_enable_in,
    input wire logic watchdog_expired_in,
    input wire logic watchdog_reset_req_out,
    input wire logic voltage_detector_enable_in,
    input wire logic voltage_detector_reset_enable_in,
    input wire logic voltage_detector_stop_enable_in,
    input wire logic supply_below_trip_in,
    input wire logic stop_mode_in,
    input wire logic low_volt_reset_req_out,
    input wire logic detector_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ======
    // Restart is held off one cycle after release
    watchdog_restart_a: assert property (
        watchdog_restart_out == (reg_wr_in && !reg_sel_in && $past(rst_n_in)))
        else $error("restart wrong");
    debug_force_a: assert property (
        reg_wr_in && reg_sel_in && reg_debug_in && reg_wdata_in[0]
        |=> force_reset_req_out) else $error("force missing");
    user_force_a: assert property (
        force_reset_req_out |-> $past(reg_wr_in && reg_sel_in && reg_debug_in
        && reg_wdata_in[0])) else $error("force unexpected");
    force_read_a: assert property (
        reg_rd_in && reg_sel_in |=> reg_rdata_out == 8'h00)
        else $error("force read");
    read_hold_a: assert property (
        !reg_rd_in |=> $stable(reg_rdata_out)) else $error("rdata moved");
    unused_bits_a: assert property (
        reg_rdata_out[3] == 1'b0 && reg_rdata_out[0] == 1'b0)
        else $error("bit 3 or 0 set");
    wd_req_a: assert property (
        watchdog_reset_req_out == (watchdog_expired_in && watchdog_enable_in))
        else $error("watchdog request");
    lv_req_a: assert property (
        low_volt_reset_req_out == (voltage_detector_enable_in &&
        (!stop_mode_in || voltage_detector_stop_enable_in) &&
        voltage_detector_reset_enable_in && supply_below_trip_in))
        else $error("low voltage request");
    detector_live_a: assert property (
        detector_active_out == (voltage_detector_enable_in &&
        (!stop_mode_in || voltage_detector_stop_enable_in)))
        else $error("detector active wrong");
endmodule
bind rcdfr_reset_cause rcdfr_chk chk_u (.*);
`default_nettype wire

// file: tb/rcdfr_host.sv
// Register host model: user program or debug host.
// Assumes calls are made just after a rising clock edge.
`default_nettype none
module rcdfr_host (
    input wire logic core_clk_in,
    input wire logic [7:0] rdata_in,
    output logic sel_out,
    output logic wr_out,
    output logic rd_out,
    output logic dbg_out,
    output logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {sel_out, wr_out, rd_out, dbg_out, wdata_out} = 12'h000;
    // ======
    // Debug flag only from the debug host path
    task automatic acc(input logic s, w, d, input logic [7:0] v,
        output logic [7:0] r);
        {sel_out, wr_out, rd_out, dbg_out, wdata_out} <= {s, w, !w, d, v};
        @(posedge core_clk_in);
        // Released data is inverted so stale values are not mistaken
        {wr_out, rd_out, dbg_out, wdata_out} <= {3'h0, ~v};
        @(negedge core_clk_in) r = rdata_in;
        @(posedge core_clk_in);
    endtask
endmodule
`default_nettype wire

// file: tb/reset_cause_and_debug_force_reset_tb_top.sv
// Testbench for the reset cause block with its host model.
// Assumes the checker is bound to the design.
`default_nettype none
module reset_cause_and_debug_force_reset_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 0, rst_n_in = 0;
    logic [6:0] c = 7'h10;
    logic [11:0] q = 12'h000;
    logic [7:0] r;
    int n_errors = 0, checked = 0, n_force = 0;
    wire reg_sel_in, reg_wr_in, reg_rd_in, reg_debug_in;
    wire [7:0] reg_wdata_in, reg_rdata_out;
    wire watchdog_restart_out, watchdog_reset_req_out, illegal_reset_req_out;
    wire low_volt_reset_req_out, detector_active_out, force_reset_req_out;
    rcdfr_reset_cause dut_u (.*, .cause_ext_pin_in(c[0]),
        .cause_watchdog_in(c[1]), .cause_illegal_in(c[2]),
        .cause_clock_gen_in(c[3]), .cause_power_on_in(c[4]),
        .cause_low_volt_in(c[5]), .cause_debug_force_in(c[6]),
        .watchdog_enable_in(q[0]), .watchdog_expired_in(q[1]),
        .illegal_opcode_in(q[2]), .stop_instr_in(q[3]), .stop_allow_in(q[4]),
        .background_entry_instruction_in(q[5]),
        .background_mode_allow_in(q[6]), .voltage_detector_enable_in(q[7]),
        .voltage_detector_reset_enable_in(q[8]), .stop_mode_in(q[11]),
        .voltage_detector_stop_enable_in(q[9]), .supply_below_trip_in(q[10]));
    rcdfr_host host_u (.core_clk_in, .rdata_in(reg_rdata_out),
        .sel_out(reg_sel_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
        .dbg_out(reg_debug_in), .wdata_out(reg_wdata_in));
    initial forever #2.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (force_reset_req_out === 1'b1) n_force++;
    // ======
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    // Reset held five cycles with the given causes, then status read back
    task automatic rst_case(logic [6:0] cv, logic [7:0] e);
        c <= cv;
        rst_n_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        {rst_n_in, c} <= 8'h80;
        repeat (2) @(posedge core_clk_in);
        host_u.acc(1'b0, 1'b0, 1'b0, 8'h00, r);
        cmp("status", e, r);
        $display("reset case done");
    endtask
    // Status write, user and debug force writes, force read
    task automatic t_regs;
        host_u.acc(1'b0, 1'b1, 1'b0, 8'hFF, r);
        host_u.acc(1'b0, 1'b0, 1'b0, 8'h00, r);
        cmp("status kept", 8'h02, r);
        host_u.acc(1'b1, 1'b1, 1'b0, 8'h01, r);
        cmp("user force", 8'h00, n_force[7:0]);
        host_u.acc(1'b1, 1'b1, 1'b1, 8'h01, r);
        host_u.acc(1'b1, 1'b0, 1'b0, 8'h00, r);
        cmp("force read", 8'h00, r);
        cmp("debug force", 8'h01, n_force[7:0]);
        $display("register test done");
    endtask
    // Every qualifier combination against the illegal request and detector active
    task automatic t_comb;
        for (int i = 0; i < 4096; i++) begin
            q <= i[11:0];
            @(negedge core_clk_in);
            cmp("illegal", {7'h00, q[2] | q[3] & !q[4] | q[5] & !q[6]},
                {7'h00, illegal_reset_req_out});
            cmp("detector", {7'h00, q[7] & (!q[11] | q[9])},
                {7'h00, detector_active_out});
            @(posedge core_clk_in);
        end
        $display("qualifier test done");
    endtask
    task automatic end_sim;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        @(posedge core_clk_in);
        rst_case(7'h10, 8'h82);
        rst_case(7'h20, 8'h82);
        rst_case(7'h03, 8'h60);
        rst_case(7'h0C, 8'h14);
        rst_case(7'h24, 8'h02);
        t_regs;
        rst_case(7'h41, 8'h00);
        t_comb;
        end_sim;
    end
    initial begin
        #40000;
        n_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
